// ===== hdl/hts_top.sv
// supervisor top: output switching, temperature diagnosis, alarm and register port
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "hts_defines.svh"
module hts_top #(
	parameter int TICK_CYC = `HTS_TICK_CYC
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	// plant pins
	input  wire logic             start_pin,
	input  wire logic             manual_heat_key,
	input  wire logic             ack_pin,
	input  wire logic             line_zc,
	// measurement and calibration
	input  wire hts_pkg::hts_temp_t act_temp,
	input  wire logic             cal_done,
	input  wire logic             cal_fail,
	input  wire logic [1:0]       cal_fail_code,
	output logic                  zero_calibration,
	// outputs
	output logic                  output1,
	output logic                  alarm_relay,
	output logic                  cycle_abort,
	output logic      [11:0]      fault_code,
	output logic      [13:0]      aout_mv,
	output logic                  startup_msg,
	output logic                  irq
);
	import hts_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and time base
	logic [2:0] pins_s;
	logic       zc_s, tick, freq_ok;
	logic [7:0] freq_hz;

	hts_sync #(.W(3)) u_sync_pins (
		.clk(clk), .sys_rst(sys_rst),
		.din({ack_pin, manual_heat_key, start_pin}), .dout(pins_s)
	);
	hts_sync #(.W(1)) u_sync_zc (
		.clk(clk), .sys_rst(sys_rst), .din(line_zc), .dout(zc_s)
	);
	hts_tick #(.TC(TICK_CYC)) u_tick (
		.clk(clk), .sys_rst(sys_rst), .zc(zc_s),
		.tick(tick), .freq_hz(freq_hz), .freq_ok(freq_ok)
	);

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] ctrl_q, ctrl_d;
	logic [7:0]  band_lo_q, band_lo_d, band_hi_q, band_hi_d;
	hts_temp_t   setpt_q, setpt_d, caltemp_q, caltemp_d;
	logic [7:0]  delay_q, delay_d, heatup_q, heatup_d;
	logic [`HTS_IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d, ev;
	logic [31:0] rdata_d;
	logic        sw_ack;
	hts_outmode_e omode;

	// decode shared by read and write
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	assign omode  = hts_outmode_e'(ctrl_q[`HTS_CTRL_OUTMODE_HI:`HTS_CTRL_OUTMODE_LO]);
	assign sw_ack = reg_wr && hit(reg_addr, `HTS_REG_CTRL) && reg_wdata[`HTS_CTRL_ACK];

	// write decode; set wins over write-one-clear
	always_comb begin
		ctrl_d    = ctrl_q;
		band_lo_d = band_lo_q;
		band_hi_d = band_hi_q;
		setpt_d   = setpt_q;
		delay_d   = delay_q;
		heatup_d  = heatup_q;
		caltemp_d = caltemp_q;
		imask_d   = imask_q;
		istat_d   = istat_q;
		if (reg_wr) begin
			if (hit(reg_addr, `HTS_REG_CTRL))
				ctrl_d = {27'h0, reg_wdata[4:0]}; // ack bit is a pulse, not stored
			if (hit(reg_addr, `HTS_REG_BAND)) begin
				band_lo_d = reg_wdata[7:0];
				band_hi_d = reg_wdata[15:8];
			end
			if (hit(reg_addr, `HTS_REG_SETPT))
				setpt_d = reg_wdata[9:0];
			if (hit(reg_addr, `HTS_REG_DELAY))
				delay_d = (reg_wdata[7:0] > `HTS_DELAY_MAX) ? `HTS_DELAY_MAX : reg_wdata[7:0];
			if (hit(reg_addr, `HTS_REG_HEATUP))
				heatup_d = reg_wdata[7:0];
			if (hit(reg_addr, `HTS_REG_CALTEMP))
				caltemp_d = reg_wdata[9:0];
			if (hit(reg_addr, `HTS_REG_IRQ_MASK))
				imask_d = reg_wdata[`HTS_IRQ_W-1:0];
			if (hit(reg_addr, `HTS_REG_IRQ_STAT))
				istat_d = istat_q & ~reg_wdata[`HTS_IRQ_W-1:0];
		end
		istat_d = istat_d | ev;
	end

	////////////////////////////////////////////////////////////////////////
	// band evaluation and diagnosis
	logic        start_q, armed_q, armed_d, latch_q, latch_d, lo_seen_q, lo_seen_d;
	logic        dly_run_q, dly_run_d, out1_d, abort_d, alarm_d, fault_q, fault_d;
	logic [7:0]  dly_cnt_q, dly_cnt_d, hu_cnt_q, hu_cnt_d;
	logic        hu_run_q, hu_run_d;
	logic [11:0] fcode_d;
	logic [10:0] lo_lim, hi_lim;
	logic        in_band, below, above, reached95, start_rise, start_fall, start_now, ack_all;

	always_comb begin
		lo_lim     = {1'b0, setpt_q} - {3'b0, band_lo_q};
		hi_lim     = {1'b0, setpt_q} + {3'b0, band_hi_q};
		below      = ({1'b0, setpt_q} < {3'b0, band_lo_q}) ? 1'b0 : ({1'b0, act_temp} < lo_lim);
		above      = {1'b0, act_temp} > hi_lim;
		in_band    = !below && !above;
		reached95  = (17'(act_temp) * 17'(`HTS_PCT_DEN)) >= (17'(setpt_q) * 17'(`HTS_PCT95_NUM));
		start_now  = pins_s[0] || pins_s[1];
		start_rise = start_now && !start_q;
		start_fall = !start_now && start_q;
		ack_all    = pins_s[2] || sw_ack;
	end

	// diagnosis, latch and fault sequencing
	always_comb begin
		armed_d   = armed_q;
		latch_d   = latch_q;
		lo_seen_d = lo_seen_q;
		dly_run_d = dly_run_q;
		dly_cnt_d = dly_cnt_q;
		hu_run_d  = hu_run_q;
		hu_cnt_d  = hu_cnt_q;
		fault_d   = fault_q;
		fcode_d   = fault_code;
		abort_d   = 1'b0;
		if (start_rise) begin
			latch_d   = 1'b1;
			armed_d   = ctrl_q[`HTS_CTRL_DIAG_EN] && in_band;
			lo_seen_d = 1'b0;
			dly_run_d = 1'b0;
			hu_run_d  = heatup_q != 8'h00;
			hu_cnt_d  = '0;
		end else if (start_now && !in_band)
			latch_d = 1'b0;
		// first low crossing starts the arming delay
		if (armed_q && below && !lo_seen_q && !start_rise) begin
			lo_seen_d = 1'b1;
			dly_run_d = 1'b1;
			dly_cnt_d = '0;
		end
		if (dly_run_q && tick)
			dly_cnt_d = dly_cnt_q + 8'd1;
		if (dly_run_q && dly_cnt_q >= delay_q)
			dly_run_d = 1'b0;
		if (hu_run_q && tick)
			hu_cnt_d = hu_cnt_q + 8'd1;
		if (hu_run_q && reached95)
			hu_run_d = 1'b0;
		if (!fault_q) begin
			if (armed_q && !dly_run_q && !(below && !lo_seen_q) && !in_band && !start_rise) begin
				fault_d = 1'b1;
				fcode_d = below ? `HTS_FC_BAND_LO : `HTS_FC_BAND_HI;
				abort_d = start_now;
				armed_d = 1'b0;
			end else if (start_fall && ctrl_q[`HTS_CTRL_DIAG_EN] && !armed_q) begin
				fault_d = 1'b1;
				fcode_d = below ? `HTS_FC_NOARM_LO : `HTS_FC_NOARM_HI;
			end else if (hu_run_q && !reached95 && hu_cnt_q >= heatup_q) begin
				fault_d  = 1'b1;
				fcode_d  = `HTS_FC_HEATUP;
				hu_run_d = 1'b0;
			end else if (cal_fail) begin
				fault_d = 1'b1;
				fcode_d = (cal_fail_code == 2'd3) ? `HTS_FC_CAL_211 : `HTS_FC_CAL_BASE + 12'(cal_fail_code);
			end
		end else if (ack_all) begin
			fault_d = 1'b0;
			fcode_d = `HTS_FC_NONE;
		end
		if (start_fall)
			armed_d = 1'b0;
		// output switching per mode
		case (omode)
			HTS_OUT_OFF:   out1_d = 1'b0;
			HTS_OUT_BAND:  out1_d = in_band && !fault_q;
			HTS_OUT_LATCH: out1_d = in_band && latch_q && !fault_q;
			default:       out1_d = 1'b0;
		endcase
		alarm_d = fault_d ^ ctrl_q[`HTS_CTRL_INVERSE];
	end

	////////////////////////////////////////////////////////////////////////
	// power-up message, calibration and analog code
	hts_pwr_e  pwr_q, pwr_d;
	logic [4:0] pwr_cnt_q, pwr_cnt_d;
	hts_temp_t shown;
	logic [13:0] aout_d;
	logic       zc_run_d, msg_d;

	always_comb begin
		pwr_d     = pwr_q;
		pwr_cnt_d = pwr_cnt_q;
		zc_run_d  = zero_calibration;
		case (pwr_q)
			HTS_PWR_MSG: begin
				if (tick)
					pwr_cnt_d = pwr_cnt_q + 5'd1;
				if (pwr_cnt_q == 5'(`HTS_STARTUP_TICKS))
					pwr_d = HTS_PWR_HOME;
			end
			HTS_PWR_HOME: begin
				if (reg_wr && hit(reg_addr, `HTS_REG_CTRL) && reg_wdata[`HTS_CTRL_CAL] && !start_now) begin
					pwr_d    = HTS_PWR_CAL;
					zc_run_d = 1'b1;
				end
			end
			HTS_PWR_CAL: begin
				if (cal_done || cal_fail) begin
					pwr_d    = HTS_PWR_HOME;
					zc_run_d = 1'b0;
				end
			end
			default: pwr_d = HTS_PWR_MSG;
		endcase
		msg_d = pwr_d == HTS_PWR_MSG;
		shown = (pwr_q == HTS_PWR_CAL && cal_done) ? caltemp_q : act_temp;
		// scale: full range is 300 or 500 degrees to 10 V
		if (pwr_d == HTS_PWR_CAL)
			aout_d = '0;
		else if (ctrl_q[`HTS_CTRL_RANGE500])
			aout_d = 14'((24'(shown) * 24'(`HTS_AOUT_NUM)) / 24'd500);
		else
			aout_d = 14'((24'(shown) * 24'(`HTS_AOUT_NUM)) / 24'd300);
	end

	// events and read mux
	always_comb begin
		ev = '0;
		ev[`HTS_IRQ_FAULT]   = fault_d && !fault_q;
		ev[`HTS_IRQ_CALDONE] = pwr_q == HTS_PWR_CAL && cal_done;
		ev[`HTS_IRQ_READY]   = pwr_q == HTS_PWR_MSG && pwr_d == HTS_PWR_HOME;
		rdata_d = '0;
		if (reg_rd) begin
			case (1'b1)
				hit(reg_addr, `HTS_REG_CTRL):     rdata_d = ctrl_q;
				hit(reg_addr, `HTS_REG_BAND):     rdata_d = {16'h0, band_hi_q, band_lo_q};
				hit(reg_addr, `HTS_REG_SETPT):    rdata_d = {22'h0, setpt_q};
				hit(reg_addr, `HTS_REG_DELAY):    rdata_d = {24'h0, delay_q};
				hit(reg_addr, `HTS_REG_HEATUP):   rdata_d = {24'h0, heatup_q};
				hit(reg_addr, `HTS_REG_STATUS):   rdata_d = {22'h0, pwr_q, hu_run_q, dly_run_q, latch_q,
				                                             armed_q, in_band, start_now, fault_q, output1};
				hit(reg_addr, `HTS_REG_FAULT):    rdata_d = {20'h0, fault_code};
				hit(reg_addr, `HTS_REG_IRQ_STAT): rdata_d = {29'h0, istat_q};
				hit(reg_addr, `HTS_REG_IRQ_MASK): rdata_d = {29'h0, imask_q};
				hit(reg_addr, `HTS_REG_CALTEMP):  rdata_d = {22'h0, caltemp_q};
				hit(reg_addr, `HTS_REG_LINEFREQ): rdata_d = {23'h0, freq_ok, freq_hz};
				default:                          rdata_d = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state registers; fault relay idle level follows inverse setting at reset = normal
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q           <= `HTS_CTRL_RESET;
			band_lo_q        <= `HTS_BAND_LO_DEF;
			band_hi_q        <= `HTS_BAND_HI_DEF;
			setpt_q          <= '0;
			delay_q          <= '0;
			heatup_q         <= '0;
			caltemp_q        <= `HTS_CALTEMP_DEF;
			imask_q          <= '0;
			istat_q          <= '0;
			start_q          <= 1'b0;
			armed_q          <= 1'b0;
			latch_q          <= 1'b0;
			lo_seen_q        <= 1'b0;
			dly_run_q        <= 1'b0;
			dly_cnt_q        <= '0;
			hu_run_q         <= 1'b0;
			hu_cnt_q         <= '0;
			fault_q          <= 1'b0;
			fault_code       <= `HTS_FC_NONE;
			output1          <= 1'b0;
			alarm_relay      <= 1'b0;
			cycle_abort      <= 1'b0;
			pwr_q            <= HTS_PWR_MSG;
			pwr_cnt_q        <= '0;
			zero_calibration <= 1'b0;
			aout_mv          <= '0;
			startup_msg      <= 1'b1;
			reg_rdata        <= '0;
			irq              <= 1'b0;
		end else begin
			ctrl_q           <= ctrl_d;
			band_lo_q        <= band_lo_d;
			band_hi_q        <= band_hi_d;
			setpt_q          <= setpt_d;
			delay_q          <= delay_d;
			heatup_q         <= heatup_d;
			caltemp_q        <= caltemp_d;
			imask_q          <= imask_d;
			istat_q          <= istat_d;
			start_q          <= start_now && pwr_q != HTS_PWR_MSG;
			armed_q          <= armed_d;
			latch_q          <= latch_d;
			lo_seen_q        <= lo_seen_d;
			dly_run_q        <= dly_run_d;
			dly_cnt_q        <= dly_cnt_d;
			hu_run_q         <= hu_run_d;
			hu_cnt_q         <= hu_cnt_d;
			fault_q          <= fault_d;
			fault_code       <= fcode_d;
			output1          <= out1_d;
			alarm_relay      <= alarm_d;
			cycle_abort      <= abort_d;
			pwr_q            <= pwr_d;
			pwr_cnt_q        <= pwr_cnt_d;
			zero_calibration <= zc_run_d;
			aout_mv          <= aout_d;
			startup_msg      <= msg_d;
			reg_rdata        <= rdata_d;
			irq              <= |(istat_d & imask_d);
		end
	end
endmodule

// ===== hdl/hts_defines.svh
// constants and register map of the heatseal temperature supervisor
//
// Functional notes
// - latch mode: output held off after band exit; here only for exits while start is on, the latch is not cleared otherwise
// - band offsets settable, default -10K/+10K
// - diagnosis arms only if in band at start
// - armed band exit gives fault 307/308
// - band violation aborts running seal cycle
// - never armed at start end: fault 309/310
// - arming delay 0..9.9s on first low crossing
// - heatup timeout from start, zero disables
// - below 95% at timeout gives fault 304
// - alarm relay polarity normal or inverse
// - accept line frequency 47 to 63 Hz
// - startup message about 2 s at power-up
// - analog code near zero during calibration
// - failed calibration gives 104..106 or 211
// - off: no function; band mode: unlatched
`ifndef HTS_DEFINES_SVH
`define HTS_DEFINES_SVH

// register offsets (byte addresses, one 32-bit word apart)
`define HTS_REG_CTRL      8'h00
`define HTS_REG_BAND      8'h04
`define HTS_REG_SETPT     8'h08
`define HTS_REG_DELAY     8'h0c
`define HTS_REG_HEATUP    8'h10
`define HTS_REG_STATUS    8'h14
`define HTS_REG_FAULT     8'h18
`define HTS_REG_IRQ_STAT  8'h1c
`define HTS_REG_IRQ_MASK  8'h20
`define HTS_REG_CALTEMP   8'h24
`define HTS_REG_LINEFREQ  8'h28

// control register fields
`define HTS_CTRL_OUTMODE_LO 0
`define HTS_CTRL_OUTMODE_HI 1
`define HTS_CTRL_DIAG_EN    2
`define HTS_CTRL_INVERSE    3
`define HTS_CTRL_RANGE500   4
`define HTS_CTRL_ACK        8
`define HTS_CTRL_CAL        7
`define HTS_CTRL_RESET      32'h0000_0002

// band defaults in kelvin
`define HTS_BAND_LO_DEF 8'h0a
`define HTS_BAND_HI_DEF 8'h0a

// fault codes
`define HTS_FC_NONE      12'h000
`define HTS_FC_HEATUP    12'd304
`define HTS_FC_BAND_LO   12'd307
`define HTS_FC_BAND_HI   12'd308
`define HTS_FC_NOARM_LO  12'd309
`define HTS_FC_NOARM_HI  12'd310
`define HTS_FC_CAL_BASE  12'd104
`define HTS_FC_CAL_211   12'd211

// timing: 200 MHz clock, 100 ms tick
`define HTS_CLK_HZ        200000000
`define HTS_TICK_MS       100
`define HTS_TICK_CYC      ((`HTS_CLK_HZ / 1000) * `HTS_TICK_MS)
`define HTS_STARTUP_MS    2000
`define HTS_STARTUP_TICKS (`HTS_STARTUP_MS / `HTS_TICK_MS)
`define HTS_DELAY_MAX     8'd99
`define HTS_CALTEMP_DEF   10'd20
`define HTS_FREQ_MIN      8'd47
`define HTS_FREQ_MAX      8'd63
`define HTS_PCT95_NUM     7'd95
`define HTS_PCT_DEN       7'd100

// analog code: degrees scaled to 0..10 V range, 1 mV/lsb
`define HTS_AOUT_NUM      14'd10000

// interrupt bits
`define HTS_IRQ_FAULT     0
`define HTS_IRQ_CALDONE   1
`define HTS_IRQ_READY     2
`define HTS_IRQ_W         3

`endif

// ===== hdl/hts_pkg.sv
// types of the heatseal temperature supervisor
package hts_pkg;
	typedef enum logic [1:0] {
		HTS_OUT_OFF   = 2'b00,
		HTS_OUT_BAND  = 2'b01,
		HTS_OUT_LATCH = 2'b10
	} hts_outmode_e;

	typedef enum logic [1:0] {
		HTS_PWR_MSG  = 2'b00,
		HTS_PWR_HOME = 2'b01,
		HTS_PWR_CAL  = 2'b10
	} hts_pwr_e;

	typedef logic [9:0] hts_temp_t;
endpackage

// ===== hdl/hts_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module hts_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] dout_d;

	// second stage is the only reader of the first
	always_comb begin
		meta_d = din;
		dout_d = meta_q;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= meta_d;
			dout   <= dout_d;
		end
	end
endmodule

// ===== hdl/hts_tick.sv
// 100 ms time base and line frequency counter
`timescale 1ns/100ps
`include "hts_defines.svh"
module hts_tick #(
	parameter int TC = `HTS_TICK_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// line zero-cross, synchronised
	input  wire logic       zc,
	// outputs
	output logic            tick,
	output logic      [7:0] freq_hz,
	output logic            freq_ok
);
	logic [24:0] cnt_q, cnt_d;
	logic [3:0]  sub_q, sub_d;
	logic [7:0]  zcnt_q, zcnt_d, freq_d;
	logic        zc_q, tick_d, ok_d;

	// one second window made of ten ticks counts zero-cross rising edges
	always_comb begin
		cnt_d  = cnt_q + 25'd1;
		tick_d = 1'b0;
		sub_d  = sub_q;
		zcnt_d = zcnt_q;
		freq_d = freq_hz;
		ok_d   = freq_ok;
		if (zc && !zc_q && zcnt_q != 8'hff)
			zcnt_d = zcnt_q + 8'd1;
		if (cnt_q == 25'(TC - 1)) begin
			cnt_d  = '0;
			tick_d = 1'b1;
			sub_d  = sub_q + 4'd1;
			if (sub_q == 4'd9) begin
				sub_d  = '0;
				freq_d = zcnt_d;
				zcnt_d = '0;
				// judged on the captured count, the window counter is already cleared here
				ok_d   = (freq_d >= `HTS_FREQ_MIN) && (freq_d <= `HTS_FREQ_MAX);
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q   <= '0;
			sub_q   <= '0;
			zcnt_q  <= '0;
			zc_q    <= 1'b0;
			tick    <= 1'b0;
			freq_hz <= '0;
			freq_ok <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			sub_q   <= sub_d;
			zcnt_q  <= zcnt_d;
			zc_q    <= zc;
			tick    <= tick_d;
			freq_hz <= freq_d;
			freq_ok <= ok_d;
		end
	end
endmodule

// ===== bench/hts_sim_tick.sv
// shorter time base for simulation: one tick is 200 cycles instead of 100 ms
package hts_sim_pkg;
	localparam int HTS_SIM_TICK_CYC = 200;
endpackage

// ===== bench/hts_plc_model.sv
// model of the supervising controller: drives start and acknowledge
`timescale 1ns/100ps
module hts_plc_model (
	// clock
	input  wire logic clk,
	// requests from the sequence
	input  wire logic want_start,
	input  wire logic want_ack,
	// status of the supervisor
	input  wire logic startup_msg,
	// plant pins
	output logic      start_pin = 1'b0,
	output logic      ack_pin   = 1'b0
);
	// start is withheld while the power-up message shows, whatever the sequence asks
	always @(posedge clk) begin
		start_pin <= want_start & ~startup_msg;
		ack_pin   <= want_ack;
	end
endmodule

// ===== bench/hts_top_assertions.sv
// port checks of the supervisor top
`timescale 1ns/100ps
`include "hts_defines.svh"
module hts_top_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// register port and pins
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        ack_pin,
	input wire logic        cal_done,
	// outputs
	input wire logic        zero_calibration,
	input wire logic        output1,
	input wire logic        alarm_relay,
	input wire logic        cycle_abort,
	input wire logic [11:0] fault_code,
	input wire logic [13:0] aout_mv,
	input wire logic        startup_msg
);
	logic       inv_q;
	logic       rng_q;
	logic [1:0] mode_q;
	logic       wr_ctl;
	logic       ack_wr;
	logic       flt;
	assign wr_ctl = reg_wr && reg_addr == `HTS_REG_CTRL;
	assign ack_wr = wr_ctl && reg_wdata[8];
	assign flt    = fault_code != 12'h000;
	// shadow of the control bits that shape outputs, since they are not on the ports
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{rng_q, inv_q, mode_q} <= 4'h2;
		end else if (wr_ctl) begin
			{rng_q, inv_q, mode_q} <= {reg_wdata[4:3], reg_wdata[1:0]};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////
	a_boot_msg: assert property ($fell(sys_rst) |-> startup_msg)
		else $error("no startup message after reset");
	a_cal_home: assert property (startup_msg |-> !zero_calibration)
		else $error("calibration during startup");
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read");
	a_abort_pulse: assert property (cycle_abort |=> !cycle_abort)
		else $error("abort longer than one cycle");
	a_abort_code: assert property ($rose(cycle_abort) |-> ##[0:4] fault_code inside {12'd307, 12'd308})
		else $error("abort without band fault");
	// ack pin passes two sync flops, so its effect lags by a few cycles
	a_fault_hold: assert property ($past(flt) && $changed(fault_code) |->
		$past(ack_pin, 2) || $past(ack_pin, 3) || $past(ack_pin, 4) || $past(ack_wr) || $past(ack_wr, 2))
		else $error("fault code changed without acknowledge");
	a_relay_pol: assert property ($stable({flt, inv_q}) [*3] |-> alarm_relay == (flt ^ inv_q))
		else $error("alarm relay polarity wrong");
	a_out_off: assert property ((mode_q == 2'h0) [*3] |-> !output1)
		else $error("switching output active in off mode");
	a_cal_zero: assert property (zero_calibration [*3] |-> aout_mv <= 14'h064)
		else $error("analog output not near zero while calibrating");
	a_cal_value: assert property (cal_done && zero_calibration |->
		##[1:3] (rng_q ? aout_mv == 14'h190 : aout_mv inside {14'h29a, 14'h29b}))
		else $error("calibration temperature not shown");
	c_abort: cover property (cycle_abort);
	c_heatup: cover property (fault_code == `HTS_FC_HEATUP);
	c_cal: cover property (cal_done && zero_calibration);
endmodule

// ===== bench/hts_top_tb_top.sv
// self-checking bench of the heatseal temperature supervisor
`timescale 1ns/100ps
`include "hts_defines.svh"
`define CHK(n, e, a) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		fail_count++; \
		$display("[ERR] %s expected %0h seen %0h", n, e, a); \
	end \
end
module hts_top_tb_top;
	import hts_pkg::*;
	localparam int TICK = hts_sim_pkg::HTS_SIM_TICK_CYC;
	logic        clk        = 1'b0;
	logic        sys_rst    = 1'b1;
	logic [7:0]  reg_addr   = 8'h00;
	logic [31:0] reg_wdata  = 32'h0;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic        want_start = 1'b0;
	logic        want_ack   = 1'b0;
	logic        line_zc    = 1'b0;
	hts_temp_t   act_temp   = 10'h0c8;
	logic        cal_done   = 1'b0;
	logic        cal_fail   = 1'b0;
	logic [1:0]  cal_code   = 2'h0;
	logic        abort_seen = 1'b0;
	logic [31:0] reg_rdata, rv;
	logic [11:0] fault_code;
	logic [13:0] aout_mv;
	logic        start_pin, ack_pin, zero_calibration, output1, alarm_relay, cycle_abort, startup_msg, irq, a;
	int          fail_count = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          n;
	hts_top #(.TICK_CYC(TICK)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_pin(start_pin), .manual_heat_key(1'b0), .ack_pin(ack_pin),
		.line_zc(line_zc), .act_temp(act_temp), .cal_done(cal_done), .cal_fail(cal_fail), .cal_fail_code(cal_code),
		.zero_calibration(zero_calibration), .output1(output1), .alarm_relay(alarm_relay), .cycle_abort(cycle_abort),
		.fault_code(fault_code), .aout_mv(aout_mv), .startup_msg(startup_msg), .irq(irq));
	hts_plc_model u_plc (.clk(clk), .want_start(want_start), .want_ack(want_ack), .startup_msg(startup_msg),
		.start_pin(start_pin), .ack_pin(ack_pin));
	initial forever #2.5 clk = ~clk;
	// 50 Hz line at the shortened time base, abort monitor and hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 20 == 19) line_zc <= ~line_zc;
		if (cycle_abort) abort_seen <= 1'b1;
		if (cyc == 150 * TICK) begin
			fail_count++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic step(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= ad;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] ad);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic chk_rd(input string s, input logic [7:0] ad, input logic [31:0] e);
		rd(ad);
		`CHK(s, e, rv)
	endtask
	task automatic start(input logic v);
		want_start <= v;
		step(8);
	endtask
	task automatic heat(input hts_temp_t v);
		act_temp <= v;
		step(8);
	endtask
	task automatic ack;
		want_ack <= 1'b1;
		step(6);
		want_ack <= 1'b0;
		step(6);
	endtask
	task automatic fc(input string s, input logic [11:0] e);
		step(6);
		`CHK(s, e, fault_code)
	endtask
	task automatic pulse(input logic fail);
		@(posedge clk);
		cal_done <= ~fail;
		cal_fail <= fail;
		@(posedge clk);
		cal_done <= 1'b0;
		cal_fail <= 1'b0;
		step(4);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		chk_rd("ctrl reset", `HTS_REG_CTRL, `HTS_CTRL_RESET);
		chk_rd("band reset", `HTS_REG_BAND, 32'h0000_0a0a);
		chk_rd("caltemp reset", `HTS_REG_CALTEMP, 32'h0000_0014);
		chk_rd("unmapped", 8'h3c, 32'h0);
		rd(`HTS_REG_LINEFREQ);
		`CHK("line freq ok", 1'b1, rv[8])
		`CHK("relay idle", 1'b0, alarm_relay)
		wr(`HTS_REG_CTRL, 32'h0a);
		step(4);
		`CHK("relay inverse", 1'b1, alarm_relay)
		wr(`HTS_REG_CTRL, 32'h02);
		$display("test regs finished");
	endtask
	task automatic t_modes;
		wr(`HTS_REG_CTRL, 32'h01);
		heat(10'd215);
		`CHK("band out", 1'b0, output1)
		heat(10'd200);
		`CHK("band in", 1'b1, output1)
		wr(`HTS_REG_CTRL, 32'h00);
		step(6);
		`CHK("off mode", 1'b0, output1)
		wr(`HTS_REG_CTRL, 32'h02);
		start(1'b1);
		`CHK("latch in", 1'b1, output1)
		heat(10'd215);
		heat(10'd200);
		start(1'b0);
		`CHK("latch held", 1'b0, output1)
		start(1'b1);
		`CHK("latch rearmed", 1'b1, output1)
		start(1'b0);
		$display("test modes finished");
	endtask
	task automatic t_diag;
		wr(`HTS_REG_CTRL, 32'h06);
		start(1'b1);
		heat(10'd215);
		`CHK("abort", 1'b1, abort_seen)
		fc("band high", `HTS_FC_BAND_HI);
		start(1'b0);
		fc("fault held", `HTS_FC_BAND_HI);
		ack();
		fc("ack pin", `HTS_FC_NONE);
		heat(10'd200);
		start(1'b1);
		heat(10'd185);
		fc("band low", `HTS_FC_BAND_LO);
		start(1'b0);
		wr(`HTS_REG_CTRL, 32'h106);
		fc("ack reg", `HTS_FC_NONE);
		start(1'b1);
		step(20);
		fc("not armed", `HTS_FC_NONE);
		start(1'b0);
		fc("no arm low", `HTS_FC_NOARM_LO);
		ack();
		heat(10'd215);
		start(1'b1);
		start(1'b0);
		fc("no arm high", `HTS_FC_NOARM_HI);
		ack();
		$display("test diagnosis finished");
	endtask
	task automatic t_timers;
		wr(`HTS_REG_DELAY, 32'h05);
		heat(10'd200);
		start(1'b1);
		heat(10'd185);
		step(2 * TICK);
		fc("delay running", `HTS_FC_NONE);
		step(5 * TICK);
		fc("delay over", `HTS_FC_BAND_LO);
		start(1'b0);
		ack();
		wr(`HTS_REG_DELAY, 32'h00);
		wr(`HTS_REG_CTRL, 32'h02);
		for (int i = 0; i < 3; i++) begin
			wr(`HTS_REG_HEATUP, (i == 2) ? 32'h0 : 32'h3);
			heat((i == 1) ? 10'd195 : 10'd100);
			start(1'b1);
			step(5 * TICK);
			fc("heatup", (i == 0) ? `HTS_FC_HEATUP : `HTS_FC_NONE);
			start(1'b0);
			ack();
		end
		$display("test timers finished");
	endtask
	task automatic t_irq;
		wr(`HTS_REG_IRQ_STAT, 32'h7);
		chk_rd("irq cleared", `HTS_REG_IRQ_STAT, 32'h0);
		wr(`HTS_REG_CTRL, 32'h06);
		heat(10'd185);
		start(1'b1);
		start(1'b0);
		rd(`HTS_REG_IRQ_STAT);
		`CHK("irq fault bit", 1'b1, rv[`HTS_IRQ_FAULT])
		wr(`HTS_REG_IRQ_MASK, 32'h0);
		step(3);
		a = irq;
		wr(`HTS_REG_IRQ_MASK, 32'h1);
		step(3);
		`CHK("irq mask", ~a, irq)
		ack();
		wr(`HTS_REG_IRQ_STAT, 32'h7);
		step(3);
		`CHK("irq clear", 1'b0, irq)
		$display("test irq finished");
	endtask
	task automatic t_cal;
		heat(10'd20);
		wr(`HTS_REG_CTRL, 32'h82);
		step(4);
		`CHK("cal running", 1'b1, zero_calibration)
		pulse(1'b0);
		`CHK("cal ended", 1'b0, zero_calibration)
		for (int c = 0; c < 4; c++) begin
			wr(`HTS_REG_CTRL, 32'h82);
			cal_code <= c[1:0];
			step(4);
			pulse(1'b1);
			fc("cal fail", (c == 3) ? `HTS_FC_CAL_211 : `HTS_FC_CAL_BASE + 12'(c));
			ack();
		end
		$display("test calibration finished");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		step(8);
		sys_rst <= 1'b0;
		n = 0;
		while (startup_msg !== 1'b0 && n < 30 * TICK) begin
			@(posedge clk);
			n++;
		end
		`CHK("startup long", 1'b1, n > 18 * TICK)
		wr(`HTS_REG_SETPT, 32'h0c8);
		t_regs();
		t_modes();
		t_diag();
		t_timers();
		t_irq();
		t_cal();
		complete_run();
	end
endmodule
bind hts_top hts_top_chk u_chk (.*);
